// ---- core/sioe_pkg.sv ----
package sioe_pkg;
  localparam int CLK_NS = 4;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [7:0] ALL_DRIVEN = 8'hFF;
  localparam logic [7:0] RELEASED_BYTE = 8'hFF;
  localparam int FRAME_BITS = 18;
  localparam int ADDR_ACK_POS = 9;
  localparam int DATA_ACK_POS = 0;
  localparam int TMR_W = 11;
  // Bus timing minima, rounded up to whole clock cycles
  localparam int T_LOW_NS = 4700;
  localparam int T_HIGH_NS = 4000;
  localparam int T_STH_NS = 4000;
  localparam int T_SPS_NS = 4000;
  localparam int T_BUF_NS = 4700;
  localparam int T_SDA_DLY_NS = 300;
  localparam logic [TMR_W-1:0] T_LOW_CYC = TMR_W'((T_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] T_HIGH_CYC = TMR_W'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] T_STH_CYC = TMR_W'((T_STH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] T_SPS_CYC = TMR_W'((T_SPS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] T_BUF_CYC = TMR_W'((T_BUF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] T_SDA_DLY_CYC = TMR_W'((T_SDA_DLY_NS + CLK_NS - 1) / CLK_NS);
  // Controller register map (byte addresses) and fields
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] REG_RXDATA = 4'h8;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RW = 1;
  localparam int CTRL_SEL_LO = 2;
  localparam int CTRL_TX_LO = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_INT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- core/sioe_if.sv ----
`timescale 1ns/10ps
interface sioe_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_int_o;
  logic dev_int_oe;
  logic scl;
  logic sda;
  logic int_n;
  // Open-drain wires with pull-ups: any enabled driver pulls low
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
  assign int_n = !(dev_int_oe && !dev_int_o);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe,
    output dev_int_o, output dev_int_oe);
  modport host (input scl, input sda, input int_n, output host_scl_o,
    output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// ---- core/sioe_device.sv ----
// Behaviour
// - Eight quasi-bidirectional pins, no direction register
// - All pins high, weak pull-up after power-up
// - Strong pull-up on written-high pins until SCL falls
// - Controller writes pin high before input use
// - Any input pin edge asserts interrupt low
// - Interrupt clears on data return or port access
// - Clear at acknowledge bit rising SCL edge
// - Changes during acknowledge pulse may be lost
// - Further changes assert interrupt after next edge
// - Other targets' transfers leave interrupt untouched
// - Start: SDA falls while SCL high
// - Stop: SDA rises while SCL high
// - Address byte MSB first: 0100, select, R/W
// - Answer addresses 0x20 to 0x27 by select pins
// - Never answer general call address
// - Acknowledge holds SDA low through ninth high
// - Select pins steady from start to stop
// - Read returns sampled pin levels
// - Write takes next byte and acknowledges it
// - Bytes after first written data ignored
// - Latch updates only from complete acknowledged byte
// - New data on pins at acknowledge rising edge
// - Reset clears bus logic, pins high weak
`timescale 1ns/10ps
module sioe_device (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  sioe_if.dev bus,
  input wire logic [2:0] addr_sel,
  input wire logic [7:0] port_pins_in,
  output logic [7:0] port_pins_out,
  output logic [7:0] port_pins_oe
);
  typedef enum logic [2:0] {
    SIOE_S_IDLE = 3'b000,
    SIOE_S_ADDR = 3'b001,
    SIOE_S_AACK = 3'b010,
    SIOE_S_WDATA = 3'b011,
    SIOE_S_WACK = 3'b100,
    SIOE_S_RDATA = 3'b101,
    SIOE_S_RACK = 3'b110,
    SIOE_S_SKIP = 3'b111
  } sioe_dst_t;

  function automatic logic addr_match(input logic [7:0] ab, input logic [2:0] sel);
    // General call (all zero) can never equal the fixed pattern
    addr_match = (ab[7:1] == {sioe_pkg::ADDR_FIXED, sel}) && (ab[7:1] != sioe_pkg::GENERAL_CALL);
  endfunction

  localparam int SYNC_W = 13;
  // Starts at idle pin levels so reset leaves no false edge or interrupt
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {3'h0, sioe_pkg::LATCH_RESET, 2'h3};
  logic [SYNC_W-1:0] in_m;
  logic [SYNC_W-1:0] in_s;
  logic scl_d;
  logic sda_d;
  logic scl_s;
  logic sda_s;
  logic [7:0] pin_s;
  logic [2:0] sel_s;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;
  sioe_dst_t state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic rw;
  logic rack_ok;
  logic [7:0] snap;
  logic int_clr;
  logic byte_done;

  assign scl_s = in_s[0];
  assign sda_s = in_s[1];
  assign pin_s = in_s[9:2];
  assign sel_s = in_s[12:10];
  assign byte_done = (cnt == 4'(sioe_pkg::BYTE_BITS));

  // Everything from the pins goes through two stages before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_m <= SYNC_IDLE;
      in_s <= SYNC_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce) begin
      in_m <= {addr_sel, port_pins_in, bus.sda, bus.scl};
      in_s <= in_m;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign start_ev = scl_s && scl_d && sda_d && !sda_s;
  assign stop_ev = scl_s && scl_d && !sda_d && sda_s;
  assign rise_ev = scl_s && !scl_d;
  assign fall_ev = !scl_s && scl_d;

  // Transfer sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SIOE_S_IDLE;
      cnt <= '0;
      shreg <= '0;
      rw <= 1'b0;
      rack_ok <= 1'b0;
    end else if (ce) begin
      if (start_ev) begin
        state <= SIOE_S_ADDR;
        cnt <= '0;
      end else if (stop_ev) begin
        state <= SIOE_S_IDLE;
      end else if (rise_ev) begin
        unique case (state)
          SIOE_S_ADDR, SIOE_S_WDATA: begin
            shreg <= {shreg[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          SIOE_S_RDATA: cnt <= cnt + 4'h1;
          SIOE_S_RACK: rack_ok <= !sda_s;
          SIOE_S_IDLE, SIOE_S_AACK, SIOE_S_WACK, SIOE_S_SKIP: begin
          end
        endcase
      end else if (fall_ev) begin
        unique case (state)
          SIOE_S_ADDR: begin
            if (byte_done) begin
              rw <= shreg[0];
              // A mismatch sits out the rest of the transfer untouched
              state <= addr_match(shreg, sel_s) ? SIOE_S_AACK : SIOE_S_SKIP;
            end
          end
          SIOE_S_AACK: begin
            cnt <= '0;
            if (rw) begin
              state <= SIOE_S_RDATA;
              shreg <= pin_s;
            end else begin
              state <= SIOE_S_WDATA;
            end
          end
          SIOE_S_WDATA: if (byte_done) state <= SIOE_S_WACK;
          SIOE_S_WACK: state <= SIOE_S_SKIP;
          SIOE_S_RDATA: begin
            if (byte_done) begin
              state <= SIOE_S_RACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
            end
          end
          SIOE_S_RACK: begin
            if (rack_ok) begin
              state <= SIOE_S_RDATA;
              shreg <= pin_s;
              cnt <= '0;
            end else begin
              state <= SIOE_S_SKIP;
            end
          end
          SIOE_S_IDLE, SIOE_S_SKIP: begin
          end
        endcase
      end
    end
  end

  // SDA is changed just after SCL falls, and released at once on a start or stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.dev_sda_oe <= 1'b0;
    end else if (ce) begin
      if (start_ev || stop_ev) begin
        bus.dev_sda_oe <= 1'b0;
      end else if (fall_ev) begin
        unique case (state)
          SIOE_S_ADDR: bus.dev_sda_oe <= byte_done && addr_match(shreg, sel_s);
          SIOE_S_AACK: bus.dev_sda_oe <= rw && !pin_s[7];
          SIOE_S_WDATA: bus.dev_sda_oe <= byte_done;
          SIOE_S_RDATA: bus.dev_sda_oe <= !byte_done && !shreg[6];
          SIOE_S_RACK: bus.dev_sda_oe <= rack_ok && !pin_s[7];
          SIOE_S_IDLE, SIOE_S_WACK, SIOE_S_SKIP: bus.dev_sda_oe <= 1'b0;
        endcase
      end
    end
  end

  // Open-drain outputs only ever pull low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.dev_sda_o <= 1'b0;
      bus.dev_int_o <= 1'b0;
    end else if (ce) begin
      bus.dev_sda_o <= 1'b0;
      bus.dev_int_o <= 1'b0;
    end
  end

  // Output latch: a 1 bit is released to the weak pull-up, a 0 bit drives low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_pins_out <= sioe_pkg::LATCH_RESET;
      port_pins_oe <= '0;
    end else if (ce) begin
      if (rise_ev && state == SIOE_S_WACK) begin
        port_pins_out <= shreg;
        // Written-high pins get a strong pull-up until SCL falls
        port_pins_oe <= sioe_pkg::ALL_DRIVEN;
      end else if (fall_ev) begin
        port_pins_oe <= ~port_pins_out;
      end
    end
  end

  // Clear acts on the acknowledge rising edge; an edge racing it can vanish
  assign int_clr = rise_ev && (state == SIOE_S_WACK || state == SIOE_S_RACK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap <= sioe_pkg::LATCH_RESET;
      bus.dev_int_oe <= 1'b0;
    end else if (ce) begin
      if (int_clr) begin
        snap <= pin_s;
        bus.dev_int_oe <= 1'b0;
      end else begin
        // Pins driven low by the latch are outputs and never interrupt
        bus.dev_int_oe <= |((pin_s ^ snap) & port_pins_out);
      end
    end
  end
endmodule // sioe_device

// ---- core/sioe_host.sv ----
`timescale 1ns/10ps
module sioe_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  sioe_if.host bus,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [2:0] {
    SIOE_H_IDLE = 3'b000,
    SIOE_H_START = 3'b001,
    SIOE_H_LOW = 3'b010,
    SIOE_H_HIGH = 3'b011,
    SIOE_H_STOP_LOW = 3'b100,
    SIOE_H_STOP_HIGH = 3'b101,
    SIOE_H_BUF = 3'b110
  } sioe_hst_t;

  localparam int FB = sioe_pkg::FRAME_BITS;
  logic [1:0] in_m;
  logic [1:0] in_s;
  logic aw_got;
  logic w_got;
  logic [3:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic go;
  logic ctrl_rw;
  logic [2:0] ctrl_sel;
  logic [7:0] ctrl_tx;
  sioe_hst_t state;
  logic [sioe_pkg::TMR_W-1:0] tmr;
  logic [4:0] idx;
  logic [FB-1:0] tx;
  logic [FB-1:0] rx;
  logic busy;
  logic nack;
  logic [7:0] rx_data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_m <= 2'h3;
      in_s <= 2'h3;
    end else if (ce) begin
      in_m <= {bus.int_n, bus.sda};
      in_s <= in_m;
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sioe_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      ws_q <= '0;
      go <= 1'b0;
      ctrl_rw <= 1'b0;
      ctrl_sel <= '0;
      ctrl_tx <= '0;
    end else if (ce) begin
      go <= 1'b0;
      s_axi_awready <= !aw_got && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_got && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q == sioe_pkg::REG_CTRL) ? sioe_pkg::RESP_OKAY : sioe_pkg::RESP_SLVERR;
        if (aw_q == sioe_pkg::REG_CTRL) begin
          if (ws_q[0]) begin
            ctrl_rw <= w_q[sioe_pkg::CTRL_RW];
            ctrl_sel <= w_q[sioe_pkg::CTRL_SEL_LO +: 3];
            go <= w_q[sioe_pkg::CTRL_GO];
          end
          if (ws_q[1]) ctrl_tx <= w_q[sioe_pkg::CTRL_TX_LO +: 8];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sioe_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= sioe_pkg::RESP_OKAY;
        s_axi_rdata <= '0;
        unique case (s_axi_araddr)
          sioe_pkg::REG_CTRL: begin
            s_axi_rdata[sioe_pkg::CTRL_RW] <= ctrl_rw;
            s_axi_rdata[sioe_pkg::CTRL_SEL_LO +: 3] <= ctrl_sel;
            s_axi_rdata[sioe_pkg::CTRL_TX_LO +: 8] <= ctrl_tx;
          end
          sioe_pkg::REG_STATUS: begin
            s_axi_rdata[sioe_pkg::ST_BUSY] <= busy;
            s_axi_rdata[sioe_pkg::ST_NACK] <= nack;
            s_axi_rdata[sioe_pkg::ST_INT] <= !in_s[1];
          end
          sioe_pkg::REG_RXDATA: s_axi_rdata[7:0] <= rx_data;
          default: s_axi_rresp <= sioe_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Bus engine: start, address byte, one data byte, stop; go while busy is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SIOE_H_IDLE;
      tmr <= '0;
      idx <= '0;
      tx <= '0;
      rx <= '0;
      busy <= 1'b0;
      nack <= 1'b0;
      rx_data <= '0;
      bus.host_scl_o <= 1'b0;
      bus.host_sda_o <= 1'b0;
      bus.host_scl_oe <= 1'b0;
      bus.host_sda_oe <= 1'b0;
    end else if (ce) begin
      tmr <= tmr + 1'b1;
      unique case (state)
        SIOE_H_IDLE: begin
          tmr <= '0;
          if (go) begin
            busy <= 1'b1;
            // A read releases SDA for the data and ends with a not-acknowledge
            tx <= {sioe_pkg::ADDR_FIXED, ctrl_sel, ctrl_rw, 1'b1,
              ctrl_rw ? sioe_pkg::RELEASED_BYTE : ctrl_tx, 1'b1};
            bus.host_sda_oe <= 1'b1;
            state <= SIOE_H_START;
          end
        end
        SIOE_H_START: begin
          if (tmr == sioe_pkg::T_STH_CYC) begin
            bus.host_scl_oe <= 1'b1;
            idx <= '0;
            tmr <= '0;
            state <= SIOE_H_LOW;
          end
        end
        SIOE_H_LOW: begin
          if (tmr == sioe_pkg::T_SDA_DLY_CYC) bus.host_sda_oe <= !tx[FB-1];
          if (tmr == sioe_pkg::T_LOW_CYC) begin
            bus.host_scl_oe <= 1'b0;
            tmr <= '0;
            state <= SIOE_H_HIGH;
          end
        end
        SIOE_H_HIGH: begin
          if (tmr == sioe_pkg::T_HIGH_CYC) begin
            rx <= {rx[FB-2:0], in_s[0]};
            tx <= {tx[FB-2:0], 1'b1};
            bus.host_scl_oe <= 1'b1;
            tmr <= '0;
            idx <= idx + 5'h1;
            state <= (idx == 5'(FB - 1)) ? SIOE_H_STOP_LOW : SIOE_H_LOW;
          end
        end
        SIOE_H_STOP_LOW: begin
          if (tmr == sioe_pkg::T_SDA_DLY_CYC) bus.host_sda_oe <= 1'b1;
          if (tmr == sioe_pkg::T_LOW_CYC) begin
            bus.host_scl_oe <= 1'b0;
            tmr <= '0;
            state <= SIOE_H_STOP_HIGH;
          end
        end
        SIOE_H_STOP_HIGH: begin
          if (tmr == sioe_pkg::T_SPS_CYC) begin
            bus.host_sda_oe <= 1'b0;
            tmr <= '0;
            state <= SIOE_H_BUF;
          end
        end
        SIOE_H_BUF: begin
          if (tmr == sioe_pkg::T_BUF_CYC) begin
            busy <= 1'b0;
            nack <= rx[sioe_pkg::ADDR_ACK_POS] || (!ctrl_rw && rx[sioe_pkg::DATA_ACK_POS]);
            rx_data <= rx[8:1];
            state <= SIOE_H_IDLE;
          end
        end
        default: state <= SIOE_H_IDLE;
      endcase
    end
  end
endmodule // sioe_host

// ---- tb/sioe_props.sv ----
`timescale 1ns/10ps
module sioe_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic [2:0] addr_sel,
  input wire logic dev_sda_oe,
  input wire logic dev_int_oe
);
  logic scl_q;
  logic sda_q;
  logic acked;
  logic [4:0] bit_cnt;
  logic [7:0] addr_byte;
  logic [10:0] hi_cnt;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev = scl && scl_q && !sda_q && sda;
  assign scl_rise = scl && !scl_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Bit position in the frame; saturates so long frames never wrap back into the address
  always_ff @(posedge aclk) begin
    if (!aresetn || start_ev) begin
      bit_cnt <= 5'h00;
    end else if (scl_rise && bit_cnt != 5'h1F) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_byte <= 8'h00;
    end else if (scl_rise && bit_cnt < 5'h08) begin
      addr_byte <= {addr_byte[6:0], sda};
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || start_ev) begin
      acked <= 1'h0;
    end else if (scl_rise && bit_cnt == 5'h08) begin
      acked <= !sda;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !scl) begin
      hi_cnt <= 11'h000;
    end else if (hi_cnt != 11'h7FF) begin
      hi_cnt <= hi_cnt + 11'h001;
    end
  end
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_int_clear;
    scl_rise && bit_cnt == 5'h11 && acked |-> ##[1:12] !dev_int_oe;
  endproperty
  a_addr_quiet: assert property (bit_cnt < 5'h08 |-> !dev_sda_oe)
    else $error("target drove SDA inside the address byte");
  a_ack_match: assert property (bit_cnt == 5'h08 && dev_sda_oe
      |-> addr_byte[7:1] == {sioe_pkg::ADDR_FIXED, addr_sel})
    else $error("acknowledge given to a foreign address");
  a_drive_rise_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("target pulled SDA while SCL high");
  a_ack_hold: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("target released SDA while SCL high");
  a_data_ack: assert property (scl_rise && bit_cnt == 5'h11 && acked && !addr_byte[0] |-> dev_sda_oe)
    else $error("written data byte not acknowledged");
  a_read_release: assert property (scl_rise && bit_cnt == 5'h11 && acked && addr_byte[0] |-> !dev_sda_oe)
    else $error("target held SDA in the controller acknowledge");
  a_int_clear: assert property (p_int_clear)
    else $error("interrupt not cleared at the data acknowledge");
  a_scl_high_time: assert property ($fell(scl) |-> hi_cnt >= sioe_pkg::T_HIGH_CYC)
    else $error("SCL high phase too short");
  c_write: cover property (scl_rise && bit_cnt == 5'h11 && acked && !addr_byte[0]);
  c_read: cover property (scl_rise && bit_cnt == 5'h11 && acked && addr_byte[0]);
  c_int: cover property ($rose(dev_int_oe));
  c_stop: cover property (stop_ev);
endmodule // sioe_props

// ---- tb/tb_serial_io_expander_port.sv ----
`timescale 1ns/10ps
module tb_serial_io_expander_port;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, strong_seen, out_scl;
  logic [1:0] bresp, rresp;
  logic [2:0] addr_sel;
  logic [3:0] awaddr, araddr, wstrb;
  logic [7:0] ext_en, ext_val, pins_out, pins_oe, pins_lvl, out_q;
  logic [31:0] wdata, rdata;
  int miscompares = 0;
  int checks_done = 0;
  sioe_if bus_if ();
  // Undriven pins sit at the weak pull-up unless the bench drives them
  assign pins_lvl = (pins_oe & pins_out) | (~pins_oe & ~(ext_en & ~ext_val));
  sioe_device sioe_device_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .bus(bus_if.dev),
    .addr_sel(addr_sel), .port_pins_in(pins_lvl), .port_pins_out(pins_out),
    .port_pins_oe(pins_oe));
  sioe_host sioe_host_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .bus(bus_if.host),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sioe_props sioe_props_inst (.aclk(aclk), .aresetn(aresetn), .scl(bus_if.scl),
    .sda(bus_if.sda), .addr_sel(addr_sel), .dev_sda_oe(bus_if.dev_sda_oe),
    .dev_int_oe(bus_if.dev_int_oe));
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (pins_oe === 8'hFF) strong_seen <= 1'h1;
    if (pins_out !== out_q) begin
      out_q <= pins_out;
      out_scl <= bus_if.scl;
    end
  end
  function automatic logic [7:0] exp_pins(input logic [7:0] latch, input logic [7:0] drv);
    return latch & drv;
  endfunction
  function automatic logic [31:0] ctrl_word(input logic [2:0] s, input logic [7:0] tx,
      input logic rw);
    return {16'h0000, tx, 3'h0, s, rw, 1'h1};
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic fail_note(input string m);
    miscompares++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic give_up(input string m);
    fail_note(m);
    complete_run();
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) fail_note($sformatf("%s got %h exp %h", m, got, exp));
  endtask
  task automatic check_bit(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) fail_note($sformatf("%s got %b exp %b", m, got, exp));
  endtask
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
    checks_done++;
    if (got !== exp) fail_note($sformatf("%s resp %h exp %h", m, got, exp));
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'h0;
    if (n == 64) give_up("write timeout");
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (n == 64) give_up("read timeout");
  endtask
  task automatic wait_idle();
    logic [31:0] st;
    logic [1:0] r;
    int n;
    axi_read(sioe_pkg::REG_STATUS, st, r);
    check_bit(st[sioe_pkg::ST_BUSY], 1'h1, "busy after go");
    for (n = 0; n < 20000 && st[sioe_pkg::ST_BUSY] !== 1'h0; n++) begin
      axi_read(sioe_pkg::REG_STATUS, st, r);
    end
    if (n == 20000) give_up("transfer timeout");
  endtask
  task automatic wait_int(input logic lvl, input string m);
    int n;
    for (n = 0; n < 40 && bus_if.int_n !== lvl; n++) @(posedge aclk);
    check_bit(bus_if.int_n, lvl, m);
  endtask
  initial begin
    logic [1:0] resp;
    logic [31:0] rd;
    logic [2:0] sel;
    logic [2:0] p;
    logic [7:0] wdat;
    logic [7:0] nv;
    int seed;
    seed = 76;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb, wdata} = {8'h00, 4'hF, 32'h0000_0000};
    {addr_sel, ext_en, ext_val, out_q} = {3'h0, 8'h00, 8'h00, 8'hFF};
    {strong_seen, out_scl} = 2'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    check_byte(pins_out, sioe_pkg::LATCH_RESET, "reset latch");
    check_byte(pins_oe, 8'h00, "reset drive");
    check_bit(bus_if.int_n, 1'h1, "reset interrupt");
    axi_write(4'hC, 32'h0000_0000, resp);
    check_resp(resp, sioe_pkg::RESP_SLVERR, "unmapped write");
    axi_read(4'hC, rd, resp);
    check_resp(resp, sioe_pkg::RESP_SLVERR, "unmapped read");
    $display("test registers done");
    sel = 3'($random(seed));
    p = 3'($random(seed));
    // Pin p is an input, its neighbour an output, the rest random
    wdat = (8'($random(seed)) | (8'h01 << p)) & ~(8'h01 << 3'(p + 3'h1));
    addr_sel <= sel;
    ext_en <= wdat;
    ext_val <= wdat;
    strong_seen <= 1'h0;
    out_scl <= 1'h0;
    axi_write(sioe_pkg::REG_CTRL, ctrl_word(sel, wdat, 1'h0), resp);
    check_resp(resp, sioe_pkg::RESP_OKAY, "ctrl write");
    wait_idle();
    axi_read(sioe_pkg::REG_STATUS, rd, resp);
    check_bit(rd[sioe_pkg::ST_NACK], 1'h0, "write acknowledged");
    check_byte(pins_out, wdat, "output latch");
    check_byte(pins_oe, ~wdat, "drive after scl fall");
    check_bit(strong_seen, 1'h1, "strong pull-up window");
    check_bit(out_scl, 1'h1, "latch changed with scl high");
    axi_read(sioe_pkg::REG_CTRL, rd, resp);
    check_byte(rd[15:8], wdat, "ctrl readback");
    check_bit(rd[sioe_pkg::CTRL_GO], 1'h0, "go reads zero");
    $display("test write done");
    ext_val <= wdat & ~(8'h01 << p);
    wait_int(1'h0, "input edge raises interrupt");
    ext_val <= wdat;
    wait_int(1'h1, "return to old value clears");
    nv = 8'($random(seed)) & ~(8'h01 << p);
    ext_val <= nv;
    wait_int(1'h0, "later change raises again");
    $display("test interrupt done");
    axi_write(sioe_pkg::REG_CTRL, ctrl_word(sel, 8'h00, 1'h1), resp);
    check_resp(resp, sioe_pkg::RESP_OKAY, "read ctrl write");
    wait_idle();
    axi_read(sioe_pkg::REG_RXDATA, rd, resp);
    check_resp(resp, sioe_pkg::RESP_OKAY, "rxdata read");
    check_byte(rd[7:0], exp_pins(wdat, nv), "read pin levels");
    check_bit(bus_if.int_n, 1'h1, "read clears interrupt");
    axi_read(sioe_pkg::REG_STATUS, rd, resp);
    check_bit(rd[sioe_pkg::ST_NACK], 1'h0, "read addressed");
    $display("test read done");
    complete_run();
  end
endmodule // tb_serial_io_expander_port
